/* File: verilog/epsel_pin_select.sv */
// expansion bus pin function select with strap capture and analog pin routing
`include "epsel_map.svh"
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Contract
// - low address, data, strobes on eighteen pins
// - six lower pins sampled as power-up straps
// - debug status lines only in development environment
// - address 8 to 19 with memory enable
// - high strobe and data need wide memory
// - analog pins: voltage inputs or remote diode
// - secondary reset enabled by flash protection word
// - gate a20 comes from plain port logic
// - configuration bits clear to zero on reset
// - io enable bit0, memory bit1, wide bit2
module epsel_pin_select (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] low_address_port_in,
    output logic [7:0] low_address_port_out,
    output logic [7:0] low_address_port_oe,
    input wire logic [7:0] low_data_port_in,
    output logic [7:0] low_data_port_out,
    output logic [7:0] low_data_port_oe,
    input wire logic [7:0] strobe_status_port_in,
    output logic [7:0] strobe_status_port_out,
    output logic [7:0] strobe_status_port_oe,
    input wire logic [7:0] mid_address_port_in,
    output logic [7:0] mid_address_port_out,
    output logic [7:0] mid_address_port_oe,
    input wire logic [4:0] high_address_port_in,
    output logic [4:0] high_address_port_out,
    output logic [4:0] high_address_port_oe,
    input wire logic [7:0] high_data_port_in,
    output logic [7:0] high_data_port_out,
    output logic [7:0] high_data_port_oe,
    input wire logic [44:0] gpio_out,
    input wire logic [44:0] gpio_oe,
    output logic [44:0] gpio_in,
    input wire logic [19:0] biu_addr,
    input wire logic [15:0] biu_data_out,
    input wire logic biu_data_oe,
    output logic [15:0] biu_data_in,
    input wire logic biu_rd_n,
    input wire logic write_strobe_low_n,
    input wire logic write_strobe_high_n,
    input wire logic [2:0] bus_status,
    input wire logic fetch_status,
    input wire logic interrupt_acknowledge_status,
    input wire logic break_reset_out,
    input wire logic protection_secondary_reset_input_enable,
    input wire logic secondary_reset_pin,
    output logic secondary_reset_input,
    output logic analog_select_diode,
    output logic development_environment,
    output logic [1:0] base_address_strap
);
    import epsel_pkg::*;

    localparam int NPIN = `EPSEL_PIN_COUNT;
    localparam int SETTLE_CYC = `EPSEL_STRAP_SETTLE_CYC;

    // group of each expansion pin, used by the mux only
    function automatic epsel_group_t pin_group(input int idx);
        if (idx < `EPSEL_BASE_LOW_DATA + 8 + 2)
            return GRP_LOW;
        else if (idx < `EPSEL_BASE_MID_ADDR)
            return GRP_DEBUG;
        else if (idx < `EPSEL_BASE_HIGH_ADDR + 4)
            return GRP_MID;
        else
            return GRP_WIDE;
    endfunction : pin_group

    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [NPIN:0] sync_pins;
    wire [NPIN:0] raw_pins = {secondary_reset_pin, high_data_port_in, high_address_port_in,
        mid_address_port_in, strobe_status_port_in, low_data_port_in, low_address_port_in};

    epsel_sync #(.WIDTH(NPIN + 1)) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .async_in(raw_pins),
        .sync_out(sync_pins)
    );

    assign gpio_in = sync_pins[NPIN-1:0];
    assign biu_data_in = {sync_pins[`EPSEL_BASE_HIGH_DATA +: 8], sync_pins[`EPSEL_BASE_LOW_DATA +: 8]};

    //////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [7:0] module_configuration;
    logic [7:0] converter_configuration;
    wire wr_modcfg = reg_write && (reg_addr == `EPSEL_MODCFG_ADDR);
    wire wr_convcfg = reg_write && (reg_addr == `EPSEL_CONVCFG_ADDR);
    wire expansion_io_enable = module_configuration[`EPSEL_BIT_IO_EN];
    wire expansion_memory_enable = module_configuration[`EPSEL_BIT_MEM_EN];
    wire expansion_memory_wide = module_configuration[`EPSEL_BIT_MEM_WIDE];
    wire remote_diode_enable = converter_configuration[`EPSEL_BIT_REMOTE_DIODE];

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            module_configuration <= `EPSEL_MODCFG_RESET;
            converter_configuration <= `EPSEL_CONVCFG_RESET;
        end
        else
        begin
            if (wr_modcfg)
                module_configuration <= reg_wdata & `EPSEL_MODCFG_MASK;
            if (wr_convcfg)
                converter_configuration <= {7'h00, reg_wdata[`EPSEL_BIT_REMOTE_DIODE]};
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // strap capture after reset release
    epsel_strap_state_t strap_state;
    logic [7:0] settle_cnt;
    logic [5:0] straps;
    wire strap_done = (strap_state == STRAP_DONE);
    wire [5:0] strap_pins = sync_pins[`EPSEL_BASE_LOW_ADDR +: `EPSEL_STRAP_PINS];

    // pins stay undriven while settling so the pull-downs set the straps
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            strap_state <= STRAP_SETTLE;
            settle_cnt <= 8'h00;
            straps <= 6'h00;
        end
        else
        begin
            case (strap_state)
                STRAP_SETTLE:
                begin
                    settle_cnt <= settle_cnt + 8'h01;
                    if (settle_cnt == 8'(SETTLE_CYC + 1))
                    begin
                        straps <= strap_pins;
                        strap_state <= STRAP_DONE;
                    end
                end
                STRAP_DONE:
                    strap_state <= STRAP_DONE;
                default:
                    strap_state <= STRAP_SETTLE;
            endcase
        end
    end

    wire dev_env = strap_done && (straps[1:0] == `EPSEL_ENV_DEV_CODE);
    assign development_environment = dev_env;
    assign base_address_strap = straps[3:2];

    //////////////////////////////////////////////////////////////////////////
    // group selection and alternate function sources
    wire sel_low = dev_env || expansion_io_enable || expansion_memory_enable;
    wire sel_debug = dev_env;
    wire sel_mid = dev_env || expansion_memory_enable;
    wire sel_wide = dev_env || (expansion_memory_enable && expansion_memory_wide);

    wire [NPIN-1:0] alt_out = {biu_data_out[15:8], write_strobe_high_n, biu_addr[19:8],
        break_reset_out, interrupt_acknowledge_status, fetch_status, bus_status,
        write_strobe_low_n, biu_rd_n, biu_data_out[7:0], biu_addr[7:0]};
    wire [NPIN-1:0] alt_oe = {{8{biu_data_oe}}, {13{1'b1}}, {6{1'b1}}, 2'b11,
        {8{biu_data_oe}}, {8{1'b1}}};

    logic [NPIN-1:0] pad_out;
    logic [NPIN-1:0] pad_oe;
    logic [NPIN-1:0] alt_sel;

    generate
        for (genvar i = 0; i < NPIN; i++)
        begin : g_pin
            localparam epsel_group_t GRP = pin_group(i);
            wire strap_hold = !strap_done && (i < `EPSEL_STRAP_PINS);
            assign alt_sel[i] = (GRP == GRP_LOW) ? sel_low :
                (GRP == GRP_DEBUG) ? sel_debug :
                (GRP == GRP_MID) ? sel_mid : sel_wide;
            // gate a20 and every other plain port pass through the gpio path
            wire next_out = alt_sel[i] ? alt_out[i] : gpio_out[i];
            wire next_oe = strap_hold ? 1'b0 : (alt_sel[i] ? alt_oe[i] : gpio_oe[i]);
            always_ff @(posedge clk_sys or negedge resetn)
            begin
                if (!resetn)
                begin
                    pad_out[i] <= 1'b0;
                    pad_oe[i] <= 1'b0;
                end
                else
                begin
                    pad_out[i] <= next_out;
                    pad_oe[i] <= next_oe;
                end
            end
        end
    endgenerate

    assign low_address_port_out = pad_out[`EPSEL_BASE_LOW_ADDR +: 8];
    assign low_address_port_oe = pad_oe[`EPSEL_BASE_LOW_ADDR +: 8];
    assign low_data_port_out = pad_out[`EPSEL_BASE_LOW_DATA +: 8];
    assign low_data_port_oe = pad_oe[`EPSEL_BASE_LOW_DATA +: 8];
    assign strobe_status_port_out = pad_out[`EPSEL_BASE_STROBE +: 8];
    assign strobe_status_port_oe = pad_oe[`EPSEL_BASE_STROBE +: 8];
    assign mid_address_port_out = pad_out[`EPSEL_BASE_MID_ADDR +: 8];
    assign mid_address_port_oe = pad_oe[`EPSEL_BASE_MID_ADDR +: 8];
    assign high_address_port_out = pad_out[`EPSEL_BASE_HIGH_ADDR +: 5];
    assign high_address_port_oe = pad_oe[`EPSEL_BASE_HIGH_ADDR +: 5];
    assign high_data_port_out = pad_out[`EPSEL_BASE_HIGH_DATA +: 8];
    assign high_data_port_oe = pad_oe[`EPSEL_BASE_HIGH_DATA +: 8];

    //////////////////////////////////////////////////////////////////////////
    // analog routing, secondary reset and register read
    wire next_secondary_reset_input = protection_secondary_reset_input_enable && sync_pins[NPIN];
    wire [7:0] strap_status = {1'b0, strap_done, straps};
    wire [7:0] next_rdata = (reg_addr == `EPSEL_MODCFG_ADDR) ? module_configuration :
        (reg_addr == `EPSEL_CONVCFG_ADDR) ? converter_configuration :
        (reg_addr == `EPSEL_STRAP_ADDR) ? strap_status : 8'h00;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            analog_select_diode <= 1'b0;
            secondary_reset_input <= 1'b0;
            reg_rdata <= 8'h00;
        end
        else
        begin
            analog_select_diode <= remote_diode_enable;
            secondary_reset_input <= next_secondary_reset_input;
            reg_rdata <= reg_read ? next_rdata : 8'h00;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_modcfg_write;
        reg_write && reg_addr == `EPSEL_MODCFG_ADDR;
    endsequence

    sequence s_modcfg_read;
        reg_read && reg_addr == `EPSEL_MODCFG_ADDR;
    endsequence

    a_low_group_route:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        (strap_done && sel_low) |=> (low_data_port_out == $past(biu_data_out[7:0])
        && strobe_status_port_out[1] == $past(write_strobe_low_n)))
    else $error("low group not routed to bus interface");

    a_strap_hold_off:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        strap_done |=> $stable(straps) && strap_done)
    else $error("straps changed after capture");

    a_strap_undriven:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        !strap_done |=> low_address_port_oe[5:0] == 6'h00)
    else $error("strap pins driven during capture");

    a_debug_dev_only:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        !dev_env |=> strobe_status_port_out[7:2] == $past(gpio_out[23:18]))
    else $error("debug lines left port logic outside development");

    a_mid_addr_route:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        (expansion_memory_enable && !dev_env) |=>
        {high_address_port_out[3:0], mid_address_port_out} == $past(biu_addr[19:8]))
    else $error("upper address not routed");

    a_wide_needs_both:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        (!dev_env && !(expansion_memory_enable && expansion_memory_wide)) |=>
        high_data_port_out == $past(gpio_out[44:37]) && high_address_port_out[4] ==
        $past(gpio_out[36]))
    else $error("high byte left port logic without wide memory");

    a_diode_route:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(remote_diode_enable) |=> analog_select_diode ##1 analog_select_diode
        || $fell(remote_diode_enable))
    else $error("diode route did not follow enable");

    a_secondary_reset_input_gate:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        !protection_secondary_reset_input_enable |=> !secondary_reset_input)
    else $error("secondary reset passed while disabled");

    a_cfg_readback:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        s_modcfg_write ##1 (s_modcfg_read and !reg_write) |=>
        reg_rdata == ($past(reg_wdata, 2) & `EPSEL_MODCFG_MASK))
    else $error("configuration readback mismatch");

    a_cfg_bits:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        (s_modcfg_write and (reg_wdata == 8'h02)) |=> expansion_memory_enable
        && !expansion_io_enable && !expansion_memory_wide)
    else $error("memory enable bit not at bit one");

    a_gpio_default:
    assert property (@(posedge clk_sys) disable iff (!resetn)
        (strap_done && !sel_mid) |=> mid_address_port_oe == $past(gpio_oe[31:24]))
    else $error("unselected pin not on port logic");
endmodule : epsel_pin_select
`default_nettype wire

/* File: common/epsel_map.svh */
// offsets, field positions, reset values and timing counts of the expansion pin select
`ifndef EPSEL_MAP_SVH
`define EPSEL_MAP_SVH

`define EPSEL_ADDR_W 8
`define EPSEL_MODCFG_ADDR 8'h10
`define EPSEL_CONVCFG_ADDR 8'h14
`define EPSEL_STRAP_ADDR 8'h18

`define EPSEL_MODCFG_RESET 8'h00
`define EPSEL_MODCFG_MASK 8'h1f
`define EPSEL_CONVCFG_RESET 8'h00
`define EPSEL_BIT_IO_EN 0
`define EPSEL_BIT_MEM_EN 1
`define EPSEL_BIT_MEM_WIDE 2
`define EPSEL_BIT_REMOTE_DIODE 0

`define EPSEL_ENV_DEV_CODE 2'b11

`define EPSEL_PIN_COUNT 45
`define EPSEL_BASE_LOW_ADDR 0
`define EPSEL_BASE_LOW_DATA 8
`define EPSEL_BASE_STROBE 16
`define EPSEL_BASE_MID_ADDR 24
`define EPSEL_BASE_HIGH_ADDR 32
`define EPSEL_BASE_HIGH_DATA 37
`define EPSEL_STRAP_PINS 6

`define EPSEL_CLK_MHZ 125
`define EPSEL_STRAP_SETTLE_NS 100
`define EPSEL_STRAP_SETTLE_CYC ((`EPSEL_STRAP_SETTLE_NS * `EPSEL_CLK_MHZ + 999) / 1000)

`endif

/* File: common/epsel_pkg.sv */
// types shared by the expansion pin select
`default_nettype none
package epsel_pkg;
    typedef enum logic [1:0]
    {
        STRAP_SETTLE = 2'b01,
        STRAP_DONE = 2'b10
    } epsel_strap_state_t;

    typedef enum logic [3:0]
    {
        GRP_LOW = 4'b0001,
        GRP_DEBUG = 4'b0010,
        GRP_MID = 4'b0100,
        GRP_WIDE = 4'b1000
    } epsel_group_t;
endpackage : epsel_pkg
`default_nettype wire

/* File: verilog/epsel_sync.sv */
// two-flop synchroniser for the expansion pin inputs
`default_nettype none
module epsel_sync #(
    parameter int WIDTH = 46
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            stage1 <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : epsel_sync
`default_nettype wire

/* File: testbench/epsel_ext_mem.sv */
// external memory and port-side devices seen from the expansion pins
`default_nettype none
module epsel_ext_mem (
    input wire logic [44:0] pin_out,
    input wire logic [44:0] pin_oe,
    input wire logic [44:0] gp_level,
    output logic [44:0] pin_in
);
    logic reading;
    logic [15:0] rd_word;
    logic [44:0] far;

    // read strobe is active low; the word is derived from the address lines
    assign reading = pin_oe[16] && !pin_out[16];
    assign rd_word = {pin_out[31:24], pin_out[7:0]} ^ 16'h5aa5;

    // outside a read the data lines show the other port devices, never stale data
    always_comb
    begin
        far = gp_level;
        if (reading)
        begin
            far[15:8] = rd_word[7:0];
            far[44:37] = rd_word[15:8];
        end
        for (int i = 0; i < 45; i++)
        begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : far[i];
        end
    end
endmodule : epsel_ext_mem
`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench for the expansion pin select
`include "epsel_map.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] low_address_port_in, low_address_port_out, low_address_port_oe;
    logic [7:0] low_data_port_in, low_data_port_out, low_data_port_oe;
    logic [7:0] strobe_status_port_in, strobe_status_port_out, strobe_status_port_oe;
    logic [7:0] mid_address_port_in, mid_address_port_out, mid_address_port_oe;
    logic [4:0] high_address_port_in, high_address_port_out, high_address_port_oe;
    logic [7:0] high_data_port_in, high_data_port_out, high_data_port_oe;
    logic [44:0] gpio_out = 45'h15a5_c3e1_d96b;
    logic [44:0] gpio_oe = 45'h0;
    logic [44:0] gp_level = 45'h0e3c_5a96_182d;
    logic [44:0] gpio_in, pin_out, pin_oe, pin_in;
    logic [19:0] biu_addr = 20'h3c1e7;
    logic [15:0] biu_data_out = 16'h6d29;
    logic [15:0] biu_data_in;
    logic biu_data_oe = 1'b1;
    logic biu_rd_n = 1'b1;
    logic write_strobe_low_n = 1'b0;
    logic write_strobe_high_n = 1'b1;
    logic [2:0] bus_status = 3'h5;
    logic fetch_status = 1'b1;
    logic interrupt_acknowledge_status = 1'b0;
    logic break_reset_out = 1'b1;
    logic protection_secondary_reset_input_enable = 1'b0;
    logic secondary_reset_pin = 1'b1;
    logic secondary_reset_input, analog_select_diode, development_environment;
    logic [1:0] base_address_strap;
    int fails = 0;
    int checks_done = 0;

    assign pin_out = {high_data_port_out, high_address_port_out, mid_address_port_out,
        strobe_status_port_out, low_data_port_out, low_address_port_out};
    assign pin_oe = {high_data_port_oe, high_address_port_oe, mid_address_port_oe,
        strobe_status_port_oe, low_data_port_oe, low_address_port_oe};
    assign {high_data_port_in, high_address_port_in, mid_address_port_in,
        strobe_status_port_in, low_data_port_in, low_address_port_in} = pin_in;

    epsel_ext_mem u_mem (.pin_out, .pin_oe, .gp_level, .pin_in);
    epsel_pin_select u_dut (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .low_address_port_in, .low_address_port_out, .low_address_port_oe,
        .low_data_port_in, .low_data_port_out, .low_data_port_oe, .strobe_status_port_in,
        .strobe_status_port_out, .strobe_status_port_oe, .mid_address_port_in,
        .mid_address_port_out, .mid_address_port_oe, .high_address_port_in,
        .high_address_port_out, .high_address_port_oe, .high_data_port_in,
        .high_data_port_out, .high_data_port_oe, .gpio_out, .gpio_oe, .gpio_in, .biu_addr,
        .biu_data_out, .biu_data_oe, .biu_data_in, .biu_rd_n, .write_strobe_low_n,
        .write_strobe_high_n, .bus_status, .fetch_status, .interrupt_acknowledge_status,
        .break_reset_out, .protection_secondary_reset_input_enable, .secondary_reset_pin,
        .secondary_reset_input, .analog_select_diode, .development_environment,
        .base_address_strap);

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    //////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [44:0] seen, input logic [44:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task print_verdict;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : settle

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        chk(what, reg_rdata, exp);
    endtask : rdc

    // write then read back with no idle cycle between the two strobes
    task automatic wrrd(input string what, input logic [7:0] a, input logic [7:0] d,
        input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        chk(what, reg_rdata, exp);
    endtask : wrrd

    // straps held long after release: capture waits for two sync flops and settling
    task automatic do_reset(input logic [5:0] straps);
        @(posedge clk_sys);
        resetn <= 1'b0;
        gp_level[5:0] <= straps;
        settle(12);
        chk("oe_in_reset", pin_oe, 45'h0);
        @(posedge clk_sys);
        resetn <= 1'b1;
        settle(40);
    endtask : do_reset

    // expected pins for one setting: alternate where selected, port logic elsewhere
    task automatic chk_sel(input logic [2:0] c, input logic d);
        logic lo, mid, wide;
        logic [44:0] sel, alt, alt_oe;
        lo = d | c[0] | c[1];
        mid = d | c[1];
        wide = d | (c[1] & c[2]);
        sel = {{9{wide}}, {12{mid}}, {6{d}}, {18{lo}}};
        alt = {biu_data_out[15:8], write_strobe_high_n, biu_addr[19:8], break_reset_out,
            interrupt_acknowledge_status, fetch_status, bus_status, write_strobe_low_n,
            biu_rd_n, biu_data_out[7:0], biu_addr[7:0]};
        alt_oe = {{8{biu_data_oe}}, {21{1'b1}}, {8{biu_data_oe}}, {8{1'b1}}};
        chk("pin_out", pin_out, (sel & alt) | (~sel & gpio_out));
        chk("pin_oe", pin_oe, (sel & alt_oe) | (~sel & gpio_oe));
    endtask : chk_sel

    //////////////////////////////////////////////////////////////////////////////
    initial
    begin
        do_reset(6'h2d);
        chk("dev_env", development_environment, 1'b0);
        chk("base_strap", base_address_strap, 2'b11);
        rdc("strap_reg", `EPSEL_STRAP_ADDR, 8'h6d);
        rdc("cfg_reset", `EPSEL_MODCFG_ADDR, 8'h00);
        rdc("conv_reset", `EPSEL_CONVCFG_ADDR, 8'h00);
        for (int c = 0; c < 8; c++)
        begin
            wrrd("cfg_wr_rd", `EPSEL_MODCFG_ADDR, 8'(c), 8'(c));
            settle(4);
            chk_sel(3'(c), 1'b0);
            rdc("cfg_rd", `EPSEL_MODCFG_ADDR, 8'(c));
        end
        wr(`EPSEL_MODCFG_ADDR, 8'hff);
        wr(8'h20, 8'h00);
        rdc("cfg_mask", `EPSEL_MODCFG_ADDR, `EPSEL_MODCFG_MASK);
        rdc("unmapped", 8'h20, 8'h00);
        wr(`EPSEL_MODCFG_ADDR, 8'h06);
        @(posedge clk_sys);
        biu_data_oe <= 1'b0;
        biu_rd_n <= 1'b0;
        settle(6);
        chk("rd_word", biu_data_in, 16'h9b42);
        wr(`EPSEL_MODCFG_ADDR, 8'h00);
        @(posedge clk_sys);
        biu_rd_n <= 1'b1;
        biu_data_oe <= 1'b1;
        gpio_oe <= 45'h0c3a_96e5_5a3c;
        settle(6);
        chk_sel(3'h0, 1'b0);
        chk("gpio_in", gpio_in, (gpio_oe & gpio_out) | (~gpio_oe & gp_level));
        wr(`EPSEL_CONVCFG_ADDR, 8'h01);
        settle(3);
        chk("diode_sel", analog_select_diode, 1'b1);
        rdc("conv_rd", `EPSEL_CONVCFG_ADDR, 8'h01);
        wr(`EPSEL_CONVCFG_ADDR, 8'h00);
        settle(3);
        chk("diode_sel", analog_select_diode, 1'b0);
        chk("secondary_reset_input_off", secondary_reset_input, 1'b0);
        // firmware would also arm an interrupt on this pin
        @(posedge clk_sys);
        protection_secondary_reset_input_enable <= 1'b1;
        settle(5);
        chk("secondary_reset_input_on", secondary_reset_input, 1'b1);
        @(posedge clk_sys);
        secondary_reset_pin <= 1'b0;
        settle(5);
        chk("secondary_reset_input_pin", secondary_reset_input, 1'b0);
        do_reset(6'h03);
        chk("dev_env", development_environment, 1'b1);
        chk_sel(3'h0, 1'b1);
        print_verdict();
    end

    // the tests take well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
